// ==== hw/bus_line_watch.sv ====
`timescale 1ns/1ps
module bus_line_watch
	import led_bank_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start_seen,
	output logic      stop_seen
);

	line_watch_s q;
	line_watch_s next_q;

	// remember last line levels
	always_comb begin
		next_q          = q;
		next_q.scl_prev = scl;
		next_q.sda_prev = sda;
		if (!rst_n) begin
			next_q.scl_prev = 1'b1;
			next_q.sda_prev = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		q <= next_q;
	end

	// edges of the clock line, and data edges while the clock line stays high
	assign scl_rise   = scl & ~q.scl_prev;
	assign scl_fall   = ~scl & q.scl_prev;
	assign start_seen = scl & q.scl_prev & q.sda_prev & ~sda;
	assign stop_seen  = scl & q.scl_prev & ~q.sda_prev & sda;

endmodule

// ==== hw/led_bank_defs.svh ====
`ifndef LED_BANK_DEFS_SVH
`define LED_BANK_DEFS_SVH

// fixed 7-bit slave address, binary 1100110
`define BUS_SLAVE_ADDR      7'h66

// register addresses
`define PAIR_A_CODE_ADDR    8'h00
`define PAIR_B_CODE_ADDR    8'h01
`define PAIR_C_CODE_ADDR    8'h02
`define ON_OFF_MASK_ADDR    8'h03

// register reset value
`define REG_RESET_VALUE     8'h00

// field positions
`define CODE_MSB            5
`define MASK_MSB            5
`define ADDR_BYTE_RW_BIT    0

// value shown for a read of an unmapped address
`define UNMAPPED_READ_VALUE 8'h00

// last bit index within a byte
`define BYTE_LAST_BIT       3'h7

`endif

// ==== hw/led_bank_pkg.sv ====
package led_bank_pkg;

	typedef enum logic [3:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ADDR_ACK,
		BUS_REG,
		BUS_REG_ACK,
		BUS_WDATA,
		BUS_WDATA_ACK,
		BUS_RDATA,
		BUS_RDATA_ACK
	} bus_state_e;

	typedef struct packed {
		logic scl_prev;
		logic sda_prev;
	} line_watch_s;

	typedef struct packed {
		bus_state_e st;
		logic [2:0] bit_cnt;
		logic       byte_done;
		logic [7:0] shift;
		logic [7:0] reg_ptr;
		logic       rd_req;
		logic       drive_low;
		logic [7:0] pair_a_current_code;
		logic [7:0] pair_b_current_code;
		logic [7:0] pair_c_current_code;
		logic [7:0] channel_on_off_mask;
		logic       enable_prev;
		logic       mode_reselect;
	} bank_state_s;

endpackage

// ==== hw/led_current_register_bank.sv ====
// Behaviour
// [R1] Four 8-bit registers (three pair-current codes and one on/off mask) are written and read over the two-wire bus.
// [R2] Address 0 holds the current code shared by both sinks of pair one.
// [R3] Address 1 holds the current code shared by both sinks of pair two.
// [R4] Address 2 holds the current code shared by both sinks of pair three.
// [R5] Address 3 holds one on bit per sink, bits 0 to 5 in the order pair one first/second, pair two first/second, pair three first/second.
// [R6] Every write to the on/off mask pulses a request to re-select the 1x or 1.5x pump mode.
// [R7] Bits 5 to 0 of a pair-current register form code N giving 0.5 mA times N plus one.
// [R8] Bits 7 and 6 of every register play no part in current codes or sink enables.
// [R9] While the enable input is low all sinks are off, and on its rise the device starts with every sink at zero current.
// [R10] The device answers slave address 1100110 and acknowledges slave address, register address and data bytes.
// [R11] A read is a register-address write, repeated start, address with read bit, one data byte, master not-acknowledge and stop.
// [R12] Reset clears all four registers, and accesses to addresses above 3 change no setting.
`timescale 1ns/1ps
`include "led_bank_defs.svh"
module led_current_register_bank
	import led_bank_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       enable,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic [5:0]      pair_one_code,
	output logic [5:0]      pair_two_code,
	output logic [5:0]      pair_three_code,
	output logic            pair_one_first_sink,
	output logic            pair_one_second_sink,
	output logic            pair_two_first_sink,
	output logic            pair_two_second_sink,
	output logic            pair_three_first_sink,
	output logic            pair_three_second_sink,
	output logic            mode_reselect
);

	bank_state_s q;
	bank_state_s next_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_seen;
	logic        stop_seen;
	logic [7:0]  read_value;

	// bus line events
	bus_line_watch u_watch (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.scl        (scl),
		.sda        (sda_in),
		.scl_rise   (scl_rise),
		.scl_fall   (scl_fall),
		.start_seen (start_seen),
		.stop_seen  (stop_seen)
	);

	// read data for the addressed register
	always_comb begin
		case (q.reg_ptr)
			`PAIR_A_CODE_ADDR: read_value = q.pair_a_current_code; // [R2]
			`PAIR_B_CODE_ADDR: read_value = q.pair_b_current_code; // [R3]
			`PAIR_C_CODE_ADDR: read_value = q.pair_c_current_code; // [R4]
			`ON_OFF_MASK_ADDR: read_value = q.channel_on_off_mask; // [R5]
			default:           read_value = `UNMAPPED_READ_VALUE;
		endcase
	end

	// bus slave, register store and mode re-select request
	always_comb begin
		next_q               = q;
		next_q.mode_reselect = 1'b0;
		next_q.enable_prev   = enable;

		// count a bit on each rising clock edge, flag the eighth
		if (scl_rise) begin
			next_q.bit_cnt = q.bit_cnt + 3'h1;
			if (q.bit_cnt == `BYTE_LAST_BIT) begin
				next_q.byte_done = 1'b1;
			end
		end

		case (q.st)
			BUS_IDLE: begin
				next_q.drive_low = 1'b0;
			end
			BUS_ADDR: begin
				if (scl_rise) begin
					next_q.shift = {q.shift[6:0], sda_in};
				end else if (scl_fall && q.byte_done) begin
					next_q.byte_done = 1'b0;
					if (q.shift[7:1] == `BUS_SLAVE_ADDR) begin // [R10]
						next_q.rd_req    = q.shift[`ADDR_BYTE_RW_BIT];
						next_q.drive_low = 1'b1;
						next_q.st        = BUS_ADDR_ACK;
					end else begin
						next_q.st = BUS_IDLE;
					end
				end
			end
			BUS_ADDR_ACK: begin
				if (scl_fall) begin
					next_q.bit_cnt   = 3'h0;
					next_q.byte_done = 1'b0;
					if (q.rd_req) begin // [R11]
						next_q.shift     = read_value;
						next_q.drive_low = ~read_value[7];
						next_q.st        = BUS_RDATA;
					end else begin
						next_q.drive_low = 1'b0;
						next_q.st        = BUS_REG;
					end
				end
			end
			BUS_REG: begin
				if (scl_rise) begin
					next_q.shift = {q.shift[6:0], sda_in};
				end else if (scl_fall && q.byte_done) begin
					next_q.byte_done = 1'b0;
					next_q.reg_ptr   = q.shift;
					next_q.drive_low = 1'b1; // [R10]
					next_q.st        = BUS_REG_ACK;
				end
			end
			BUS_REG_ACK: begin
				if (scl_fall) begin
					next_q.bit_cnt   = 3'h0;
					next_q.byte_done = 1'b0;
					next_q.drive_low = 1'b0;
					next_q.st        = BUS_WDATA;
				end
			end
			BUS_WDATA: begin
				if (scl_rise) begin
					next_q.shift = {q.shift[6:0], sda_in};
				end else if (scl_fall && q.byte_done) begin
					next_q.byte_done = 1'b0;
					next_q.drive_low = 1'b1; // [R10]
					next_q.st        = BUS_WDATA_ACK;
					// store, addresses above 3 are acknowledged but ignored
					case (q.reg_ptr) // [R1] [R12]
						`PAIR_A_CODE_ADDR: next_q.pair_a_current_code = q.shift; // [R2]
						`PAIR_B_CODE_ADDR: next_q.pair_b_current_code = q.shift; // [R3]
						`PAIR_C_CODE_ADDR: next_q.pair_c_current_code = q.shift; // [R4]
						`ON_OFF_MASK_ADDR: begin
							next_q.channel_on_off_mask = q.shift; // [R5]
							next_q.mode_reselect       = 1'b1; // [R6]
						end
						default: next_q.reg_ptr = q.reg_ptr;
					endcase
				end
			end
			BUS_WDATA_ACK: begin
				// one data byte per write; further bytes are not acknowledged
				if (scl_fall) begin
					next_q.drive_low = 1'b0;
					next_q.st        = BUS_IDLE;
				end
			end
			BUS_RDATA: begin
				if (scl_fall) begin
					if (q.byte_done) begin
						next_q.byte_done = 1'b0;
						next_q.drive_low = 1'b0;
						next_q.st        = BUS_RDATA_ACK;
					end else begin
						next_q.shift     = {q.shift[6:0], 1'b0};
						next_q.drive_low = ~q.shift[6];
					end
				end
			end
			BUS_RDATA_ACK: begin
				// master not-acknowledge ends the read, acknowledge repeats it
				if (scl_rise) begin
					if (sda_in) begin // [R11]
						next_q.st = BUS_IDLE;
					end
				end else if (scl_fall) begin
					// byte_done was cleared on entry, so the ninth fall alone reloads
					next_q.byte_done = 1'b0;
					next_q.bit_cnt   = 3'h0;
					next_q.shift     = read_value;
					next_q.drive_low = ~read_value[7];
					next_q.st        = BUS_RDATA;
				end
			end
			default: begin
				next_q.st        = BUS_IDLE;
				next_q.drive_low = 1'b0;
			end
		endcase

		// start and stop override any byte in progress
		if (start_seen) begin
			next_q.st        = BUS_ADDR;
			next_q.bit_cnt   = 3'h0;
			next_q.byte_done = 1'b0;
			next_q.drive_low = 1'b0;
		end else if (stop_seen) begin
			next_q.st        = BUS_IDLE;
			next_q.drive_low = 1'b0;
		end

		// shutdown holds the four registers, bus state and data drive cleared; leaving it asks for a mode pick
		if (!enable) begin // [R9]
			next_q.st                  = BUS_IDLE;
			next_q.drive_low           = 1'b0;
			next_q.byte_done           = 1'b0;
			next_q.pair_a_current_code = `REG_RESET_VALUE;
			next_q.pair_b_current_code = `REG_RESET_VALUE;
			next_q.pair_c_current_code = `REG_RESET_VALUE;
			next_q.channel_on_off_mask = `REG_RESET_VALUE;
		end else if (!q.enable_prev) begin
			next_q.mode_reselect = 1'b1; // [R9]
		end

		// synchronous reset
		if (!rst_n) begin // [R12]
			next_q.st                  = BUS_IDLE;
			next_q.bit_cnt             = 3'h0;
			next_q.byte_done           = 1'b0;
			next_q.shift               = 8'h00;
			next_q.reg_ptr             = 8'h00;
			next_q.rd_req              = 1'b0;
			next_q.drive_low           = 1'b0;
			next_q.pair_a_current_code = `REG_RESET_VALUE;
			next_q.pair_b_current_code = `REG_RESET_VALUE;
			next_q.pair_c_current_code = `REG_RESET_VALUE;
			next_q.channel_on_off_mask = `REG_RESET_VALUE;
			next_q.enable_prev         = 1'b0;
			next_q.mode_reselect       = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		q <= next_q;
	end

	// open-drain data line: only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe  = q.drive_low;

	// codes and sink enables; top two bits are not used
	assign pair_one_code          = q.pair_a_current_code[`CODE_MSB:0]; // [R7] [R8]
	assign pair_two_code          = q.pair_b_current_code[`CODE_MSB:0]; // [R7] [R8]
	assign pair_three_code        = q.pair_c_current_code[`CODE_MSB:0]; // [R7] [R8]
	assign pair_one_first_sink    = q.channel_on_off_mask[0]; // [R5] [R8]
	assign pair_one_second_sink   = q.channel_on_off_mask[1]; // [R5]
	assign pair_two_first_sink    = q.channel_on_off_mask[2]; // [R5]
	assign pair_two_second_sink   = q.channel_on_off_mask[3]; // [R5]
	assign pair_three_first_sink  = q.channel_on_off_mask[4]; // [R5]
	assign pair_three_second_sink = q.channel_on_off_mask[`MASK_MSB]; // [R5]
	assign mode_reselect          = q.mode_reselect; // [R6]

endmodule

// ==== test/bank_monitor.sv ====
`timescale 1ns/1ps
module bank_monitor (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       enable,
	input wire logic       scl,
	input wire logic       sda_oe,
	input wire logic [5:0] pair_one_code,
	input wire logic [5:0] pair_two_code,
	input wire logic [5:0] pair_three_code,
	input wire logic       pair_one_first_sink,
	input wire logic       pair_one_second_sink,
	input wire logic       pair_two_first_sink,
	input wire logic       pair_two_second_sink,
	input wire logic       pair_three_first_sink,
	input wire logic       pair_three_second_sink,
	input wire logic       mode_reselect
);
	wire [23:0] outs;
	// codes then sink enables, mask bit 0 lowest
	assign outs = {pair_one_code, pair_two_code, pair_three_code, pair_three_second_sink,
		pair_three_first_sink, pair_two_second_sink, pair_two_first_sink,
		pair_one_second_sink, pair_one_first_sink};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// enable taken high after a low cycle
	sequence s_wake;
		!enable ##1 enable;
	endsequence
	a_off_disabled: assert property (!enable |=> outs == 24'h0)
		else $error("not cleared");
	a_wake_clean: assert property (s_wake |=> mode_reselect && outs == 24'h0)
		else $error("bad wake");
	a_pulse_single: assert property (mode_reselect |=> !mode_reselect)
		else $error("long pulse");
	a_code_cause: assert property ($changed(outs[23:6]) |-> $rose(sda_oe) || !$past(enable))
		else $error("code moved");
	a_mask_write: assert property ($changed(outs[5:0]) && $past(enable) |-> mode_reselect)
		else $error("no reselect");
	a_quiet_off: assert property (!enable [*3] |-> !sda_oe)
		else $error("drives while off");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
		else $error("sda moved, scl high");
	a_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*4])
		else $error("short drive");
endmodule
bind led_current_register_bank bank_monitor mon (.mclk, .rst_n, .enable, .scl, .sda_oe,
	.pair_one_code, .pair_two_code, .pair_three_code, .pair_one_first_sink,
	.pair_one_second_sink, .pair_two_first_sink, .pair_two_second_sink,
	.pair_three_first_sink, .pair_three_second_sink, .mode_reselect);

// ==== test/bus_master_model.sv ====
`timescale 1ns/1ps
module bus_master_model (
	input wire logic mclk,
	input wire logic sda,
	output logic     scl = 1'b1,
	output logic     pull = 1'b0
);
	task automatic hold();
		repeat (2) @(negedge mclk);
	endtask
	// one slot: pull set while scl low, line sampled and pull changed while high
	task automatic slot(input logic a, b, c, output logic r);
		hold();
		pull = a;
		hold();
		scl = 1'b1;
		hold();
		r = sda;
		pull = b;
		hold();
		scl = c;
	endtask
	// byte msb first, then the ninth slot with sda released
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) slot(!d[i], !d[i], 1'b0, q[i]);
		slot(1'b0, 1'b0, 1'b0, r);
		ack = !r;
	endtask
	// register write, or address write, repeated start and one byte read
	task automatic op(input logic [6:0] sa, input logic [7:0] ra, wd, input logic rd,
		output logic [7:0] q, output logic ok);
		logic r, k1, k2, k3;
		logic k4 = 1'b0;
		slot(1'b0, 1'b1, 1'b0, r);
		xfer({sa, 1'b0}, q, k1);
		xfer(ra, q, k2);
		if (rd) begin
			slot(1'b0, 1'b1, 1'b0, r);
			xfer({sa, 1'b1}, q, k3);
			xfer(8'hFF, q, k4);
		end else begin
			xfer(wd, q, k3);
		end
		slot(1'b1, 1'b0, 1'b1, r);
		ok = k1 & k2 & k3 & !k4;
	endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`include "led_bank_defs.svh"
module tb_top;
	logic       mclk = 1'b0;
	logic       rst_n, enable, scl, pull, sda_out, sda_oe, mode_reselect, ok, r;
	logic [3:0] k;
	logic [5:0] c1, c2, c3, sk;
	logic [7:0] q, d, a;
	wire        sda = !(pull | (sda_oe & !sda_out));
	int         n_fail, n_checks, n_pulse, p0;
	int         mdl[4];
	led_current_register_bank uut (.mclk, .rst_n, .enable, .scl, .sda_in(sda), .sda_out,
		.sda_oe, .pair_one_code(c1), .pair_two_code(c2), .pair_three_code(c3),
		.pair_one_first_sink(sk[0]), .pair_one_second_sink(sk[1]),
		.pair_two_first_sink(sk[2]), .pair_two_second_sink(sk[3]),
		.pair_three_first_sink(sk[4]), .pair_three_second_sink(sk[5]), .mode_reselect);
	bus_master_model m (.mclk, .sda, .scl, .pull);
	// clock and pulse counter
	initial forever #10 mclk = ~mclk;
	always @(posedge mclk) if (mode_reselect === 1'b1) n_pulse++;
	task automatic check(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic outs();
		check({c1, c2, c3, sk}, {mdl[0][5:0], mdl[1][5:0], mdl[2][5:0], mdl[3][5:0]});
	endtask
	task automatic acc(input logic [6:0] sa, input logic [7:0] ra, wd, input logic rd, ek);
		m.op(sa, ra, wd, rd, q, ok);
		check(ok, ek);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		#1000000;
		n_fail++;
		$display("MISMATCH %0t timeout", $time);
		give_verdict();
	end
	initial begin
		rst_n = 1'b0;
		enable = 1'b0;
		void'($urandom(32'h296C5008));
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		enable = 1'b1;
		repeat (3) @(negedge mclk);
		check(n_pulse, 1);
		outs();
		for (int i = 0; i < 4; i++) begin
			acc(`BUS_SLAVE_ADDR, i[7:0], 8'h00, 1'b1, 1'b1);
			check(q, 0);
		end
		$display("reset test done");
		// top code, zero code with high bits, then random values
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 4; i++) begin
				d = (r == 0) ? 8'hFF : (r == 1) ? 8'hC0 : 8'($urandom);
				p0 = n_pulse;
				acc(`BUS_SLAVE_ADDR, i[7:0], d, 1'b0, 1'b1);
				mdl[i] = d;
				check(n_pulse - p0, i == 3);
				outs();
				acc(`BUS_SLAVE_ADDR, i[7:0], 8'h00, 1'b1, 1'b1);
				check(q, d);
			end
		end
		$display("write test done");
		a = 8'h04 + 8'($urandom % 252);
		acc(`BUS_SLAVE_ADDR, a, 8'($urandom), 1'b0, 1'b1);
		acc(`BUS_SLAVE_ADDR, a, 8'h00, 1'b1, 1'b1);
		check(q, 0);
		outs();
		acc(`BUS_SLAVE_ADDR ^ 7'h01, 8'h00, 8'h2A, 1'b0, 1'b0);
		outs();
		$display("address test done");
		// a second data byte in one write is refused, the first one lands
		m.slot(1'b0, 1'b1, 1'b0, r);
		m.xfer({`BUS_SLAVE_ADDR, 1'b0}, q, k[0]);
		m.xfer(8'h01, q, k[1]);
		m.xfer(8'h15, q, k[2]);
		m.xfer(8'h2B, q, k[3]);
		m.slot(1'b1, 1'b0, 1'b1, r);
		mdl[1] = 'h15;
		check(k, 4'b0111);
		outs();
		// read answered with a master acknowledge sends the same byte again
		m.slot(1'b0, 1'b1, 1'b0, r);
		m.xfer({`BUS_SLAVE_ADDR, 1'b0}, q, k[0]);
		m.xfer(8'h01, q, k[1]);
		m.slot(1'b0, 1'b1, 1'b0, r);
		m.xfer({`BUS_SLAVE_ADDR, 1'b1}, q, k[2]);
		for (int i = 7; i >= 0; i--) m.slot(1'b0, 1'b0, 1'b0, q[i]);
		m.slot(1'b1, 1'b1, 1'b0, r);
		check(q, 8'h15);
		m.xfer(8'hFF, q, k[3]);
		m.slot(1'b1, 1'b0, 1'b1, r);
		check({q, k}, {8'h15, 4'b0111});
		$display("burst test done");
		// shutdown clears and ignores the bus, wake pulses reselect
		enable = 1'b0;
		mdl = '{0, 0, 0, 0};
		repeat (3) @(negedge mclk);
		outs();
		acc(`BUS_SLAVE_ADDR, 8'h03, 8'h3F, 1'b0, 1'b0);
		p0 = n_pulse;
		enable = 1'b1;
		repeat (3) @(negedge mclk);
		check(n_pulse - p0, 1);
		outs();
		$display("shutdown test done");
		give_verdict();
	end
endmodule
